// File: common/ssdi_pkg.sv
`default_nettype none
package ssdi_pkg;
    // ****************************************************************
    // Register map.
    // ****************************************************************
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
    localparam logic [7:0] ADDR_POSITION = 8'h10;
    // ****************************************************************
    // Configuration fields.
    // ****************************************************************
    localparam int CFG_RES_LSB = 0;
    localparam int CFG_LOW_ACTIVE = 3;
    localparam int CFG_PLC_LEVEL = 4;
    localparam int CFG_REDUCE_OFF = 5;
    localparam int CFG_DOUBLE_STEP = 6;
    localparam int CFG_MECH_BRIDGE = 7;
    localparam int CFG_ENCODER = 8;
    localparam logic [8:0] CFG_RESET = 9'h080;
    // ****************************************************************
    // Fault and interrupt bits.
    // ****************************************************************
    localparam int EV_UNDERVOLT = 0;
    localparam int EV_SHORT = 1;
    localparam int EV_OVERTEMP = 2;
    localparam int EV_MECH = 3;
    localparam int EV_CONFIG = 4;
    localparam int EV_COUNT = 5;
    // ****************************************************************
    // Resolutions in steps per revolution.
    // ****************************************************************
    localparam logic [10:0] RES_200 = 11'h0C8;
    localparam logic [10:0] RES_400 = 11'h190;
    localparam logic [10:0] RES_500 = 11'h1F4;
    localparam logic [10:0] RES_800 = 11'h320;
    localparam logic [10:0] RES_1000 = 11'h3E8;
    localparam logic [10:0] RES_NONE = 11'h000;
    // ****************************************************************
    // Current levels in percent of the set value.
    // ****************************************************************
    localparam logic [7:0] CUR_OFF = 8'h00;
    localparam logic [7:0] CUR_HALF = 8'h32;
    localparam logic [7:0] CUR_FULL = 8'h64;
    localparam logic [7:0] CUR_BOOST = 8'h78;
    // ****************************************************************
    // Timing.
    // ****************************************************************
    localparam int CLK_HZ = 20_000_000;
    localparam int STANDSTILL_MS = 100;
    localparam int STANDSTILL_CYC = CLK_HZ / 1000 * STANDSTILL_MS;
    localparam int LOAD_ANGLE_MAX = 16;
endpackage
`default_nettype wire

// File: rtl/ssdi_indexer.sv
// Notes on behaviour
// - Three switches select one of six settings; settings 1 and 4 both give 400, so five resolutions.
// - Halve phase current at standstill when enabled.
// - First pulse restores full phase current.
// - No current reduction while reset active.
// - Double step: both pulse edges step.
// - Two switches select input polarity and level.
// - Reset clears errors, zeroes phase, ignores pulses.
// - Disable switches all phase currents off.
// - Boost raises current by one fifth.
// - One step per pulse, direction input sets sense.
// - Step angle input halves selected resolution.
// - Step angle low-active, only with bit0 off.
// - Ready contact closed unless an electrical fault or a counted mechanical fault exists; config faults leave it closed.
// - Mechanical error counts only with bridge open.
// - Encoder variant compares steps with encoder pulses.
// - Four phase indicators, two yellow fault indicators.
//
// The placing of the registers and the APB register port are this design's own decisions.
`default_nettype none
module ssdi_indexer #(
    parameter int STANDSTILL_CYCLES = ssdi_pkg::STANDSTILL_CYC,
    parameter int LOAD_ANGLE = ssdi_pkg::LOAD_ANGLE_MAX
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic reset_i,
    // APB slave.
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Host control inputs.
    input wire logic pulse_i,
    input wire logic direction_i,
    input wire logic drive_reset_i,
    input wire logic disable_i,
    input wire logic boost_i,
    input wire logic step_angle_n_i,
    // Power stage and encoder.
    input wire logic undervolt_i,
    input wire logic short_i,
    input wire logic overtemp_i,
    input wire logic enc_pulse_i,
    input wire logic enc_dir_i,
    // Drive outputs.
    output logic step_o,
    output logic step_dir_o,
    output logic [1:0] phase_o,
    output logic [7:0] current_pct_o,
    output logic [10:0] resolution_o,
    // Indicators and interrupt.
    output logic [3:0] phase_led_o,
    output logic elec_led_o,
    output logic mech_led_o,
    output logic ready_o,
    output logic irq_o
);
    logic [8:0] config_r;
    logic [4:0] irq_status;
    logic [4:0] irq_mask;
    logic [4:0] fault;
    logic prev_pulse;
    logic prev_enc;
    logic [1:0] phase;
    logic reduced;
    logic [31:0] idle_count;
    logic signed [15:0] lag;
    logic [15:0] position;
    // ****************************************************************
    // Input conditioning.
    // ****************************************************************
    logic low_active;
    logic cfg_bad;
    logic pulse_act;
    logic dir_act;
    logic rst_act;
    logic dis_act;
    logic boost_act;
    logic pulse_edge;
    logic enc_edge;
    logic step_now;
    logic apb_wr;
    logic [4:0] events;
    logic mech_en;
    logic any_fault;
    logic [10:0] base_res;
    logic res_bad;
    always_comb
    begin
        low_active = config_r[ssdi_pkg::CFG_LOW_ACTIVE];
        // Both polarity switches on is an illegal setting.
        cfg_bad = low_active & config_r[ssdi_pkg::CFG_PLC_LEVEL];
        pulse_act = pulse_i ^ low_active;
        dir_act = direction_i ^ low_active;
        rst_act = drive_reset_i ^ low_active;
        dis_act = disable_i ^ low_active;
        boost_act = boost_i ^ low_active;
        if (config_r[ssdi_pkg::CFG_DOUBLE_STEP])
        begin
            pulse_edge = pulse_act ^ prev_pulse;
        end
        else
        begin
            pulse_edge = pulse_act & ~prev_pulse;
        end
        enc_edge = enc_pulse_i & ~prev_enc;
        // Pulses are ignored while reset, an electrical fault or a counted mechanical fault holds the drive; config faults do not block them.
        step_now = pulse_edge & ~rst_act & ~any_fault;
        apb_wr = psel_i & penable_i & pwrite_i;
    end
    // ****************************************************************
    // Resolution selection.
    // ****************************************************************
    always_comb
    begin
        res_bad = 1'b0;
        unique case (config_r[ssdi_pkg::CFG_RES_LSB +: 3])
            3'h0: base_res = ssdi_pkg::RES_800;
            3'h1: base_res = ssdi_pkg::RES_400;
            3'h2: base_res = ssdi_pkg::RES_1000;
            3'h3: base_res = ssdi_pkg::RES_500;
            3'h4: base_res = ssdi_pkg::RES_400;
            3'h5: base_res = ssdi_pkg::RES_200;
            default:
            begin
                base_res = ssdi_pkg::RES_NONE;
                res_bad = 1'b1;
            end
        endcase
    end
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            resolution_o <= ssdi_pkg::RES_800;
        end
        else if (~step_angle_n_i & ~config_r[ssdi_pkg::CFG_RES_LSB])
        begin
            resolution_o <= base_res >> 1;
        end
        else
        begin
            resolution_o <= base_res;
        end
    end
    // ****************************************************************
    // Step sequencing.
    // ****************************************************************
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            prev_pulse <= 1'b0;
            prev_enc <= 1'b0;
            phase <= 2'h0;
            position <= 16'h0000;
            step_o <= 1'b0;
            step_dir_o <= 1'b0;
        end
        else
        begin
            prev_pulse <= pulse_act;
            prev_enc <= enc_pulse_i;
            step_o <= step_now;
            step_dir_o <= dir_act;
            if (rst_act)
            begin
                phase <= 2'h0;
            end
            else if (step_now)
            begin
                phase <= dir_act ? phase + 2'h1 : phase - 2'h1;
                position <= dir_act ? position + 16'h0001
                                    : position - 16'h0001;
            end
        end
    end
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            phase_o <= 2'h0;
            phase_led_o <= 4'h1;
        end
        else
        begin
            phase_o <= phase;
            phase_led_o <= 4'h1 << phase;
        end
    end
    // ****************************************************************
    // Load angle monitor.
    // ****************************************************************
    always_ff @(posedge clk_i)
    begin
        if (reset_i | rst_act | ~config_r[ssdi_pkg::CFG_ENCODER])
        begin
            lag <= 16'sh0000;
        end
        else
        begin
            // Commanded steps add, encoder steps subtract.
            lag <= lag + (step_now ? (dir_act ? 16'sh0001 : -16'sh0001)
                                   : 16'sh0000)
                       - (enc_edge ? (enc_dir_i ? 16'sh0001 : -16'sh0001)
                                   : 16'sh0000);
        end
    end
    // ****************************************************************
    // Standstill current reduction.
    // ****************************************************************
    always_ff @(posedge clk_i)
    begin
        if (reset_i | rst_act | step_now)
        begin
            idle_count <= 32'h0;
            reduced <= 1'b0;
        end
        else if (~config_r[ssdi_pkg::CFG_REDUCE_OFF])
        begin
            if (idle_count >= 32'(STANDSTILL_CYCLES - 1))
            begin
                reduced <= 1'b1;
            end
            else
            begin
                idle_count <= idle_count + 32'h1;
            end
        end
        else
        begin
            reduced <= 1'b0;
        end
    end
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            current_pct_o <= ssdi_pkg::CUR_OFF;
        end
        else if (dis_act | any_fault | cfg_bad | res_bad)
        begin
            current_pct_o <= ssdi_pkg::CUR_OFF;
        end
        else if (reduced)
        begin
            current_pct_o <= ssdi_pkg::CUR_HALF;
        end
        else if (boost_act)
        begin
            current_pct_o <= ssdi_pkg::CUR_BOOST;
        end
        else
        begin
            current_pct_o <= ssdi_pkg::CUR_FULL;
        end
    end
    // ****************************************************************
    // Faults, ready contact and indicators.
    // ****************************************************************
    always_comb
    begin
        events = 5'h00;
        events[ssdi_pkg::EV_UNDERVOLT] = undervolt_i;
        events[ssdi_pkg::EV_SHORT] = short_i;
        events[ssdi_pkg::EV_OVERTEMP] = overtemp_i;
        events[ssdi_pkg::EV_MECH] = config_r[ssdi_pkg::CFG_ENCODER]
            & ((lag > 16'(LOAD_ANGLE)) | (lag < -16'(LOAD_ANGLE)));
        events[ssdi_pkg::EV_CONFIG] = cfg_bad | res_bad;
        mech_en = ~config_r[ssdi_pkg::CFG_MECH_BRIDGE];
        any_fault = |fault[2:0] | (fault[ssdi_pkg::EV_MECH] & mech_en);
    end
    always_ff @(posedge clk_i)
    begin
        if (reset_i | rst_act)
        begin
            fault <= 5'h00;
        end
        else
        begin
            fault <= fault | events;
        end
    end
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            ready_o <= 1'b0;
            elec_led_o <= 1'b0;
            mech_led_o <= 1'b0;
        end
        else
        begin
            ready_o <= ~any_fault;
            elec_led_o <= |fault[2:0];
            mech_led_o <= fault[ssdi_pkg::EV_MECH]
                          & config_r[ssdi_pkg::CFG_ENCODER];
        end
    end
    // ****************************************************************
    // Interrupts.
    // ****************************************************************
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            irq_status <= 5'h00;
        end
        else if (apb_wr & (paddr_i == ssdi_pkg::ADDR_IRQ_STATUS))
        begin
            irq_status <= (irq_status & ~pwdata_i[4:0]) | events;
        end
        else
        begin
            irq_status <= irq_status | events;
        end
    end
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            irq_o <= 1'b0;
        end
        else
        begin
            irq_o <= |(irq_status & irq_mask);
        end
    end
    // ****************************************************************
    // APB slave.
    // ****************************************************************
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            config_r <= ssdi_pkg::CFG_RESET;
            irq_mask <= 5'h00;
        end
        else if (apb_wr & (paddr_i == ssdi_pkg::ADDR_CONFIG))
        begin
            config_r <= pwdata_i[8:0];
        end
        else if (apb_wr & (paddr_i == ssdi_pkg::ADDR_IRQ_MASK))
        begin
            irq_mask <= pwdata_i[4:0];
        end
    end
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            prdata_o <= 32'h0000_0000;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end
        else
        begin
            pready_o <= psel_i & ~penable_i;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
            if (psel_i & ~penable_i)
            begin
                unique case (paddr_i)
                    ssdi_pkg::ADDR_CONFIG:
                        prdata_o <= {23'h0, config_r};
                    ssdi_pkg::ADDR_STATUS:
                        prdata_o <= {22'h00_0000, ready_o, reduced,
                                     phase, 1'h0, fault};
                    ssdi_pkg::ADDR_IRQ_STATUS:
                        prdata_o <= {27'h0, irq_status};
                    ssdi_pkg::ADDR_IRQ_MASK:
                        prdata_o <= {27'h0, irq_mask};
                    ssdi_pkg::ADDR_POSITION:
                        prdata_o <= {16'h0, position};
                    default:
                        pslverr_o <= 1'b1;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// File: verification/ssdi_host_model.sv
`default_nettype none
// *****
// Host pulse generator.
// *****
module ssdi_host_model (
    // Clock, reset and request.
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic start_i,
    input wire logic dir_i,
    input wire logic low_i,
    input wire logic [7:0] count_i,
    input wire logic [9:0] gap_i,
    // Host lines.
    output logic pulse_o,
    output logic dir_o,
    output logic busy_o
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [9:0] MIN_HALF = 10'h0DF;
    logic [8:0] left;
    logic [9:0] cnt;
    logic level;
    always_ff @(posedge clk_i)
    begin
        if (reset_i || start_i)
        begin
            left <= reset_i ? 9'h000 : {count_i, 1'b0};
            cnt <= 10'h000;
            level <= 1'b0;
        end
        else if (left != 9'h000)
        begin
            if (cnt >= gap_i && cnt >= MIN_HALF)
            begin
                level <= ~level;
                left <= left - 9'h001;
                cnt <= 10'h000;
            end
            else
                cnt <= cnt + 10'h001;
        end
    end
    assign pulse_o = level ^ low_i;
    assign dir_o = dir_i ^ low_i;
    assign busy_o = left != 9'h000;
endmodule
`default_nettype wire

// File: verification/ssdi_checker.sv
`default_nettype none
// *****
// Port checker.
// *****
module ssdi_checker #(
    parameter int STANDSTILL_CYCLES = 20
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic reset_i,
    // Observed ports.
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pready_o,
    input wire logic drive_reset_i,
    input wire logic undervolt_i,
    input wire logic short_i,
    input wire logic overtemp_i,
    input wire logic step_o,
    input wire logic [1:0] phase_o,
    input wire logic [7:0] current_pct_o,
    input wire logic [10:0] resolution_o,
    input wire logic [3:0] phase_led_o,
    input wire logic elec_led_o,
    input wire logic ready_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int idle_cnt;
    logic [2:0] quiet;
    logic drv_prev;
    logic fault;
    assign fault = undervolt_i || short_i || overtemp_i;
    always_ff @(posedge clk_i)
    begin
        if (reset_i || step_o)
            idle_cnt <= 0;
        else if (idle_cnt < 32'h000F4240)
            idle_cnt <= idle_cnt + 1;
    end
    always_ff @(posedge clk_i)
    begin
        drv_prev <= drive_reset_i;
        if (reset_i || drive_reset_i != drv_prev)
            quiet <= 3'h0;
        else if (quiet != 3'h7)
            quiet <= quiet + 3'h1;
    end
    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    AST_RES_LEGAL: assert property (
        resolution_o inside {11'h000, 11'h0C8, 11'h190, 11'h1F4, 11'h320,
        11'h3E8}) else $error("bad resolution");
    AST_LED_ONEHOT: assert property (
        phase_led_o == 4'h1 << phase_o) else $error("bad phase led");
    AST_FAULT_OPEN: assert property (
        fault |-> ##[1:3] !ready_o) else $error("ready stayed closed");
    AST_FAULT_LED: assert property (
        fault |-> ##[1:3] elec_led_o) else $error("fault led dark");
    AST_FAULT_HOLD: assert property (
        elec_led_o && quiet == 3'h7 |=> elec_led_o) else $error("fault lost");
    AST_NO_STEP_FAULT: assert property (
        elec_led_o && $past(elec_led_o) && $past(elec_led_o, 2) |-> !step_o)
        else $error("step while faulted");
    AST_STEP_MOVES: assert property (
        step_o |-> ##[0:1] $changed(phase_o)) else $error("phase kept");
    AST_RESTORE: assert property (
        step_o && current_pct_o == 8'h32 |-> ##[0:2] current_pct_o != 8'h32)
        else $error("current stayed low");
    AST_REDUCE_IDLE: assert property (
        $changed(current_pct_o) && current_pct_o == 8'h32
        |-> idle_cnt >= STANDSTILL_CYCLES - 3) else $error("early reduction");
    AST_APB_ANSWER: assert property (
        psel_i && !penable_i |=> pready_o) else $error("no bus answer");
    AST_RESET_ZERO: assert property (
        $fell(reset_i) |-> phase_o == 2'h0 && !step_o)
        else $error("reset left state");
endmodule
bind ssdi_indexer ssdi_checker #(
    .STANDSTILL_CYCLES(STANDSTILL_CYCLES)
) ssdi_checker_inst (
    .clk_i, .reset_i, .psel_i, .penable_i, .pready_o, .drive_reset_i,
    .undervolt_i, .short_i, .overtemp_i, .step_o, .phase_o,
    .current_pct_o, .resolution_o, .phase_led_o, .elec_led_o, .ready_o
);
`default_nettype wire

// File: verification/ssdi_indexer_bench.sv
`default_nettype none
// *****
// Indexer bench.
// *****
module ssdi_indexer_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int STAND = 300;
    logic clk_i = 1'b0, reset_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0;
    logic pwrite_i = 1'b0, drive_reset_i = 1'b0, disable_i = 1'b0;
    logic boost_i = 1'b0, step_angle_n_i = 1'b1, undervolt_i = 1'b0;
    logic short_i = 1'b0, overtemp_i = 1'b0, enc_pulse_i = 1'b0;
    logic enc_dir_i = 1'b0, start = 1'b0, hdir = 1'b0, low = 1'b0;
    logic follow = 1'b0, err, a, d, busy, pulse_i, direction_i;
    logic [7:0] paddr_i = 8'h00, hcnt = 8'h00, current_pct_o;
    logic [31:0] pwdata_i = 32'h0, q, prdata_o;
    logic [9:0] gap = 10'h0E6;
    logic [1:0] s1, phase_o;
    logic pready_o, pslverr_o, step_o, step_dir_o, elec_led_o, mech_led_o;
    logic ready_o, irq_o;
    logic [10:0] resolution_o;
    logic [3:0] phase_led_o;
    int mismatches = 0, checked = 0, steps = 0, b, n, net;
    ssdi_indexer #(
        .STANDSTILL_CYCLES(STAND),
        .LOAD_ANGLE(4)
    ) ssdi_indexer_inst (
        .clk_i, .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .pulse_i,
        .direction_i, .drive_reset_i, .disable_i, .boost_i,
        .step_angle_n_i, .undervolt_i, .short_i, .overtemp_i,
        .enc_pulse_i, .enc_dir_i, .step_o, .step_dir_o, .phase_o,
        .current_pct_o, .resolution_o, .phase_led_o, .elec_led_o,
        .mech_led_o, .ready_o, .irq_o
    );
    ssdi_host_model ssdi_host_model_inst (
        .clk_i, .reset_i, .start_i(start), .dir_i(hdir), .low_i(low),
        .count_i(hcnt), .gap_i(gap), .pulse_o(pulse_i),
        .dir_o(direction_i), .busy_o(busy)
    );
    always #25 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        if (step_o === 1'b1)
            steps++;
        enc_pulse_i <= follow & step_o;
        enc_dir_i <= step_dir_o;
    end
    task automatic finish_test();
        if (mismatches == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic stall();
        mismatches++;
        finish_test();
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] ad,
        input logic [31:0] dt);
        int k;
        k = 0;
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= ad;
        pwdata_i <= dt;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do
        begin
            @(posedge clk_i);
            k++;
        end
        while (pready_o !== 1'b1 && k < 16);
        q = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (pready_o !== 1'b1)
            stall();
    endtask
    task automatic cfg(input logic [31:0] dt);
        apb(1'b1, ssdi_pkg::ADDR_CONFIG, dt);
        repeat (3) @(posedge clk_i);
    endtask
    task automatic dres();
        drive_reset_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        drive_reset_i <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask
    task automatic pulses(input int cnt, input logic dir);
        int k;
        k = 0;
        @(posedge clk_i);
        start <= 1'b1;
        hcnt <= cnt[7:0];
        hdir <= dir;
        @(posedge clk_i);
        start <= 1'b0;
        do
        begin
            @(posedge clk_i);
            k++;
        end
        while (busy !== 1'b0 && k < 20000);
        if (busy !== 1'b0)
            stall();
        repeat (6) @(posedge clk_i);
    endtask
    function automatic logic [10:0] exp_res(input logic [2:0] c,
        input logic sn);
        logic [10:0] r;
        case (c)
            3'h0: r = 11'h320;
            3'h1, 3'h4: r = 11'h190;
            3'h2: r = 11'h3E8;
            3'h3: r = 11'h1F4;
            3'h5: r = 11'h0C8;
            default: r = 11'h000;
        endcase
        if (!sn && !c[0])
            r = r >> 1;
        return r;
    endfunction
    initial
    begin
        repeat (90000) @(posedge clk_i);
        stall();
    end
    initial
    begin
        void'($urandom(32'h8fc5));
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        apb(1'b1, 8'h40, 32'hFFFFFFFF);
        check(32'(err), 32'h1);
        apb(1'b0, 8'h40, 32'h0);
        check(q, 32'h0);
        apb(1'b0, ssdi_pkg::ADDR_CONFIG, 32'h0);
        check(q, 32'(ssdi_pkg::CFG_RESET));
        apb(1'b0, ssdi_pkg::ADDR_STATUS, 32'h0);
        check(32'(q[9]), 32'h1);
        for (int c = 0; c < 16; c++)
        begin
            step_angle_n_i <= c[3];
            cfg({29'h14, c[2:0]});
            check(32'(resolution_o), 32'(exp_res(c[2:0], c[3])));
        end
        step_angle_n_i <= 1'b1;
        cfg(32'h0B8);
        check(32'(current_pct_o), 32'h0);
        apb(1'b0, ssdi_pkg::ADDR_IRQ_STATUS, 32'h0);
        check(32'(q[4]), 32'h1);
        apb(1'b1, ssdi_pkg::ADDR_IRQ_MASK, 32'h0);
        repeat (2) @(posedge clk_i);
        a = irq_o;
        apb(1'b1, ssdi_pkg::ADDR_IRQ_MASK, 32'h1F);
        repeat (2) @(posedge clk_i);
        check(32'(a ^ irq_o), 32'h1);
        cfg(32'h0B0);
        check(32'(current_pct_o), 32'h64);
        cfg(32'h0A0);
        apb(1'b1, ssdi_pkg::ADDR_IRQ_STATUS, 32'h1F);
        apb(1'b0, ssdi_pkg::ADDR_IRQ_STATUS, 32'h0);
        check(q, 32'h0);
        check(32'(irq_o), 32'h0);
        dres();
        check(32'(phase_o), 32'h0);
        b = steps;
        pulses(1, 1'b1);
        s1 = phase_o;
        check(32'(steps - b), 32'h1);
        check(32'(s1[0]), 32'h1);
        net = 1;
        for (int i = 0; i < 4; i++)
        begin
            n = $urandom_range(1, 3);
            d = 1'($urandom_range(0, 1));
            gap <= 10'($urandom_range(100, 400));
            pulses(n, d);
            net += d ? n : -n;
            check(32'(phase_o), 32'(2'(net * s1)));
            check(32'(step_dir_o), 32'(d));
        end
        apb(1'b0, ssdi_pkg::ADDR_POSITION, 32'h0);
        check(q, {16'h0000, 16'(net)});
        gap <= 10'h0E6;
        cfg(32'h0E0);
        b = steps;
        pulses(2, 1'b1);
        check(32'(steps - b), 32'h4);
        cfg(32'h0A8);
        drive_reset_i <= 1'b1;
        disable_i <= 1'b1;
        boost_i <= 1'b1;
        low <= 1'b1;
        repeat (4) @(posedge clk_i);
        b = steps;
        pulses(3, 1'b1);
        check(32'(steps - b), 32'h3);
        cfg(32'h0A0);
        drive_reset_i <= 1'b0;
        disable_i <= 1'b0;
        boost_i <= 1'b0;
        low <= 1'b0;
        cfg(32'h080);
        repeat (STAND + 10) @(posedge clk_i);
        check(32'(current_pct_o), 32'h32);
        pulses(1, 1'b1);
        check(32'(current_pct_o), 32'h64);
        drive_reset_i <= 1'b1;
        repeat (STAND + 20) @(posedge clk_i);
        check(32'(current_pct_o), 32'h64);
        drive_reset_i <= 1'b0;
        cfg(32'h0A0);
        boost_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        check(32'(current_pct_o), 32'h78);
        disable_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        check(32'(current_pct_o), 32'h0);
        disable_i <= 1'b0;
        boost_i <= 1'b0;
        for (int f = 0; f < 3; f++)
        begin
            {overtemp_i, short_i, undervolt_i} <= 3'(1 << f);
            @(posedge clk_i);
            {overtemp_i, short_i, undervolt_i} <= 3'h0;
            repeat (10) @(posedge clk_i);
            check(32'({elec_led_o, ready_o}), 32'h2);
            b = steps;
            pulses(1, 1'b1);
            check(32'(steps - b), 32'h0);
            apb(1'b0, ssdi_pkg::ADDR_IRQ_STATUS, 32'h0);
            check(32'(q[f]), 32'h1);
            dres();
            check(32'({elec_led_o, ready_o}), 32'h1);
            apb(1'b1, ssdi_pkg::ADDR_IRQ_STATUS, 32'h1F);
        end
        cfg(32'h120);
        follow <= 1'b1;
        pulses(6, 1'b1);
        check(32'({mech_led_o, ready_o}), 32'h1);
        follow <= 1'b0;
        pulses(6, 1'b1);
        check(32'({mech_led_o, ready_o}), 32'h2);
        dres();
        cfg(32'h1A0);
        pulses(6, 1'b1);
        check(32'(ready_o), 32'h1);
        finish_test();
    end
endmodule
`default_nettype wire
